// >>> core/pfsa_ctrl.sv
/*
 * Program flash self-access sequencer: address, data, control and key
 * registers, hidden row write latches, read cycle stealing, keyed erase and
 * row program with processor stall, keyed latch load, and protection settings.
 * Assumes the flash array answers a read in the same cycle as flash_rd_en and
 * that the processor honours force_nop and stall on every cycle.
 */
// Notes on behaviour
// - data pair forms one 14-bit word
// - address pair holds 15-bit word address
// - high register gives upper bits, low byte
// - go bits set-only, hardware clears at end
// - erase or write needs modify_permit, reset clear
// - reset during write sets interrupted_op_flag
// - unlock key register reads as zero
// - rows of 32 words, 32 latches
// - hidden latches loaded via data pair
// - read steals second slot, data next cycle
// - data pair held until read or write
// - keyed sequence starts erase, load, program
// - program_go forces two no-op slots
// - erase or program stalls for 2 ms
// - latch load forces no-ops, no stall
// - readout_lock zero blocks external access only
// - readout lock cleared only by bulk erase
// - guard blocks self-write, not external access
// - row erase with row_clear and permit set
// - latch_only loads latch, else programs row
// - bits above 4 pick row, 4:0 latch
// - latches return blank after program or erase
`timescale 1ns/100ps
`default_nettype none
module pfsa_ctrl #(
  parameter int unsigned OP_CYCLES = pfsa_pkg::OP_CYCLES,
  parameter logic [14:0] SMALL_END = pfsa_pkg::GUARD_SMALL_END,
  parameter logic [14:0] HALF_END  = pfsa_pkg::GUARD_HALF_END
) (
  // Clock and resets.
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        dev_reset,
  // Processor register access.
  input  wire pfsa_pkg::pfsa_req_t         cpu_req,
  input  wire pfsa_pkg::pfsa_sel_t         cpu_rd_sel,
  output var  logic [7:0]                  cpu_rdata,
  output var  logic                        cpu_force_nop,
  output var  logic                        cpu_stall,
  // Flash array side.
  output var  logic                        flash_rd_en,
  output var  logic [14:0]                 flash_addr,
  input  wire logic [13:0]                 flash_rd_data,
  output var  logic                        flash_erase_start,
  output var  logic                        flash_prog_start,
  output var  logic [31:0][13:0]           flash_row_data,
  // Configuration settings and external programmer.
  input  wire logic                        readout_lock,
  input  wire logic [1:0]                  self_program_guard,
  input  wire logic                        bulk_erase,
  output var  logic                        ext_access_ok
);
  localparam int TW = $clog2(OP_CYCLES + 1);
  localparam logic [TW-1:0] T_LAST = TW'(OP_CYCLES - 1);

  // Whole state of the block, registered in one place.
  typedef struct packed {
    pfsa_pkg::pfsa_state_t state;     // Sequencer state.
    pfsa_pkg::pfsa_key_t   key;       // Unlock key progress.
    logic [6:0]            ctl;       // flash_control_reg bits.
    logic [14:0]           addr;      // Word address pair.
    logic [13:0]           data;      // Data word pair.
    logic [31:0][13:0]     latch;     // Hidden row write latches.
    logic [TW-1:0]         timer;     // Erase and program timer.
    logic                  long_op;   // Current keyed op stalls.
    logic                  erase_op;  // Current keyed op erases.
    logic                  lock;      // Readout protection in force.
    logic                  lock_init; // Lock strap captured.
    logic [7:0]            rdata;     // Read port register.
    logic                  force_nop; // Slot suppression output.
    logic                  stall;     // Processor stall output.
    logic                  rd_en;     // Array read strobe.
    logic                  erase_go;  // Erase start pulse.
    logic                  prog_go;   // Program start pulse.
  } pfsa_st_t;

  pfsa_st_t st_reg;
  pfsa_st_t st_next;
  logic     guard_hit;  // Current address is shielded from self-write.
  logic     key_pass;   // A keyed start would be honoured now.
  logic     busy_write; // A keyed write or erase is under way.

  // Guard decode on the current row address.
  always_comb begin
    case (self_program_guard)
      pfsa_pkg::GUARD_OFF:   guard_hit = 1'b0;
      pfsa_pkg::GUARD_SMALL: guard_hit = st_reg.addr < SMALL_END;
      pfsa_pkg::GUARD_HALF:  guard_hit = st_reg.addr < HALF_END;
      default:               guard_hit = 1'b1;
    endcase
  end

  assign key_pass = (st_reg.key == pfsa_pkg::KEY_OK) &&
                    st_reg.ctl[pfsa_pkg::CTL_PERMIT] && !guard_hit &&
                    !st_reg.ctl[pfsa_pkg::CTL_CFG_SPACE];
  assign busy_write = st_reg.ctl[pfsa_pkg::CTL_PROGRAM_GO];

  // Next-state logic for the whole block.
  always_comb begin
    st_next = st_reg;
    st_next.erase_go = 1'b0;
    st_next.prog_go  = 1'b0;
    st_next.rd_en    = 1'b0;
    // lock caught once, cleared only by bulk erase
    if (!st_reg.lock_init) begin
      st_next.lock_init = 1'b1;
      st_next.lock      = !readout_lock;
    end else if (bulk_erase) begin
      st_next.lock = 1'b0;
    end else if (!readout_lock) begin
      st_next.lock = 1'b1;
    end
    // Software writes; any write other than the key breaks the key.
    if (cpu_req.wr) begin
      if (cpu_req.sel != pfsa_pkg::SEL_KEY) begin
        st_next.key = pfsa_pkg::KEY_NONE;
      end
      case (cpu_req.sel)
        pfsa_pkg::SEL_KEY: begin
          if (cpu_req.wdata == pfsa_pkg::KEY_FIRST) begin
            st_next.key = pfsa_pkg::KEY_HALF;
          end else if (cpu_req.wdata == pfsa_pkg::KEY_SECOND &&
                       st_reg.key == pfsa_pkg::KEY_HALF) begin
            st_next.key = pfsa_pkg::KEY_OK;
          end else begin
            st_next.key = pfsa_pkg::KEY_NONE;
          end
        end
        pfsa_pkg::SEL_CTRL: begin
          // go bits only set by software
          st_next.ctl = {cpu_req.wdata[6:2], st_reg.ctl[1:0]};
          // Clear of the error flag is allowed; the hardware set below wins.
          if (st_reg.state == pfsa_pkg::ST_IDLE) begin
            if (cpu_req.wdata[pfsa_pkg::CTL_READ_GO]) begin
              // read begins, slot two is stolen
              st_next.ctl[pfsa_pkg::CTL_READ_GO] = 1'b1;
              st_next.state = pfsa_pkg::ST_RD_WAIT;
            end else if (cpu_req.wdata[pfsa_pkg::CTL_PROGRAM_GO] &&
                         key_pass) begin
              st_next.ctl[pfsa_pkg::CTL_PROGRAM_GO] = 1'b1;
              st_next.state = pfsa_pkg::ST_NOP1;
              st_next.erase_op = st_reg.ctl[pfsa_pkg::CTL_ROW_CLEAR];
              st_next.long_op = st_reg.ctl[pfsa_pkg::CTL_ROW_CLEAR] ||
                                !st_reg.ctl[pfsa_pkg::CTL_LATCH_ONLY];
            end
          end
          if (busy_write) begin
            // permit and selects frozen while a write runs
            st_next.ctl[6:2] = st_reg.ctl[6:2];
            st_next.ctl[pfsa_pkg::CTL_INTERRUPT] =
              cpu_req.wdata[pfsa_pkg::CTL_INTERRUPT] &&
              st_reg.ctl[pfsa_pkg::CTL_INTERRUPT];
          end
        end
        // two bytes make one 14-bit word
        pfsa_pkg::SEL_DAT_L: st_next.data[7:0]  = cpu_req.wdata;
        pfsa_pkg::SEL_DAT_H: st_next.data[13:8] = cpu_req.wdata[5:0];
        pfsa_pkg::SEL_ADR_L: st_next.addr[7:0]  = cpu_req.wdata;
        // upper address bits from the high register
        pfsa_pkg::SEL_ADR_H: st_next.addr[14:8] = cpu_req.wdata[6:0];
        default: st_next.key = pfsa_pkg::KEY_NONE;
      endcase
    end
    // Sequencer.
    case (st_reg.state)
      pfsa_pkg::ST_IDLE: begin
      end
      pfsa_pkg::ST_RD_WAIT: begin
        // First slot after the read start still executes.
        st_next.state = pfsa_pkg::ST_RD_SLOT;
        st_next.rd_en = 1'b1;
      end
      pfsa_pkg::ST_RD_SLOT: begin
        // the pair changes only here or by software
        st_next.data  = flash_rd_data;
        st_next.ctl[pfsa_pkg::CTL_READ_GO] = 1'b0;
        st_next.state = pfsa_pkg::ST_IDLE;
      end
      pfsa_pkg::ST_NOP1: begin
        st_next.state = pfsa_pkg::ST_NOP2;
      end
      pfsa_pkg::ST_NOP2: begin
        if (st_reg.long_op) begin
          st_next.state    = pfsa_pkg::ST_TIMING;
          st_next.timer    = '0;
          st_next.erase_go = st_reg.erase_op;
          st_next.prog_go  = !st_reg.erase_op;
        end else begin
          // load one hidden latch from the data pair
          // low five address bits pick the latch
          st_next.latch[st_reg.addr[pfsa_pkg::LATCH_W-1:0]] = st_reg.data;
          st_next.state = pfsa_pkg::ST_FINISH;
        end
      end
      pfsa_pkg::ST_TIMING: begin
        st_next.timer = st_reg.timer + TW'(1);
        if (st_reg.timer == T_LAST) begin
          // latches blank again after erase or program
          for (int i = 0; i < pfsa_pkg::ROW_WORDS; i++) begin
            st_next.latch[i] = pfsa_pkg::BLANK_WORD;
          end
          st_next.state = pfsa_pkg::ST_FINISH;
        end
      end
      pfsa_pkg::ST_FINISH: begin
        st_next.ctl[pfsa_pkg::CTL_PROGRAM_GO] = 1'b0;
        st_next.state = pfsa_pkg::ST_IDLE;
      end
      default: st_next.state = pfsa_pkg::ST_IDLE;
    endcase
    // Outputs follow the next state so they leave flip-flops in step.
    // latch load forces the slots only
    st_next.force_nop = (st_next.state == pfsa_pkg::ST_NOP1) ||
                        (st_next.state == pfsa_pkg::ST_NOP2) ||
                        (st_next.state == pfsa_pkg::ST_RD_SLOT);
    st_next.stall = st_next.state == pfsa_pkg::ST_TIMING;
    case (cpu_rd_sel)
      pfsa_pkg::SEL_CTRL:  st_next.rdata = {1'b0, st_reg.ctl};
      pfsa_pkg::SEL_DAT_L: st_next.rdata = st_reg.data[7:0];
      pfsa_pkg::SEL_DAT_H: st_next.rdata = {2'h0, st_reg.data[13:8]};
      pfsa_pkg::SEL_ADR_L: st_next.rdata = st_reg.addr[7:0];
      pfsa_pkg::SEL_ADR_H: st_next.rdata = {1'b0, st_reg.addr[14:8]};
      default:             st_next.rdata = 8'h00;
    endcase
    // device reset during a write flags it and aborts the sequencer.
    if (dev_reset) begin
      st_next.state = pfsa_pkg::ST_IDLE;
      st_next.key   = pfsa_pkg::KEY_NONE;
      st_next.ctl   = 7'h00;
      st_next.ctl[pfsa_pkg::CTL_INTERRUPT] =
        busy_write || st_reg.ctl[pfsa_pkg::CTL_INTERRUPT];
      st_next.force_nop = 1'b0;
      st_next.stall     = 1'b0;
      st_next.erase_go  = 1'b0;
      st_next.prog_go   = 1'b0;
      st_next.rd_en     = 1'b0;
    end
  end

  // State register; power-on reset clears permit and all control.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg       <= '0;
      st_reg.latch <= {pfsa_pkg::ROW_WORDS{pfsa_pkg::BLANK_WORD}};
      st_reg.lock  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign cpu_rdata         = st_reg.rdata;
  assign cpu_force_nop     = st_reg.force_nop;
  assign cpu_stall         = st_reg.stall;
  assign flash_rd_en       = st_reg.rd_en;
  // any address in the row selects it
  assign flash_addr        = st_reg.addr;
  assign flash_erase_start = st_reg.erase_go;
  assign flash_prog_start  = st_reg.prog_go;
  assign flash_row_data    = st_reg.latch;
  // lock hides flash from external tools only
  // guard never reaches the external path
  assign ext_access_ok     = !st_reg.lock;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_key_start_gate: assert property (
    $rose(st_reg.state == pfsa_pkg::ST_NOP1) |->
      $past(st_reg.key) == pfsa_pkg::KEY_OK && $past(st_reg.ctl[2]))
    else $error("keyed start without key or permit");
  a_two_nop_slots: assert property (
    $rose(st_reg.state == pfsa_pkg::ST_NOP1) && !dev_reset |->
      cpu_force_nop ##1 (cpu_force_nop || dev_reset))
    else $error("program start did not force two slots");
  a_stall_length: assert property (
    $fell(cpu_stall) && !$past(dev_reset) |-> $past(st_reg.timer) == T_LAST)
    else $error("stall ended before the timer ran out");
  a_latch_blank: assert property (
    $rose(st_reg.state == pfsa_pkg::ST_FINISH) && $past(cpu_stall) |->
      flash_row_data == {pfsa_pkg::ROW_WORDS{pfsa_pkg::BLANK_WORD}})
    else $error("latches not blank after erase or program");
  a_read_capture: assert property (
    flash_rd_en && !dev_reset |=> st_reg.data == $past(flash_rd_data))
    else $error("read word not captured in the data pair");
  a_read_slot: assert property (
    $rose(st_reg.ctl[0]) && !dev_reset |=> flash_rd_en && cpu_force_nop)
    else $error("second slot not stolen for the read");
  a_key_reads_zero: assert property (
    cpu_rd_sel == pfsa_pkg::SEL_KEY |=> cpu_rdata == 8'h00)
    else $error("key register read back non-zero");
  a_reset_flag: assert property (
    dev_reset && st_reg.ctl[1] |=> st_reg.ctl[3])
    else $error("interrupted write not flagged");
  a_latch_no_stall: assert property (
    $rose(st_reg.state == pfsa_pkg::ST_NOP1) && !st_reg.long_op |->
      !cpu_stall [*3])
    else $error("latch load stalled the processor");
  a_go_held: assert property (
    st_reg.ctl[1] && st_reg.state == pfsa_pkg::ST_TIMING && !dev_reset |=>
      st_reg.ctl[1])
    else $error("program_go dropped during the operation");
  // The read bit is a one-shot: it must not outlive the stolen slot.
  a_read_go_clear: assert property (
    st_reg.state == pfsa_pkg::ST_RD_SLOT && !dev_reset |=>
      !st_reg.ctl[pfsa_pkg::CTL_READ_GO])
    else $error("read_go not cleared after the read");
  // The data pair may only move on a read capture or a software write.
  a_data_hold: assert property (
    !flash_rd_en && !cpu_req.wr |=> $stable(st_reg.data))
    else $error("data pair changed without a read or write");
  // Without permission no keyed start may ever reach the slot states.
  a_permit_needed: assert property (
    !st_reg.ctl[pfsa_pkg::CTL_PERMIT] &&
      st_reg.state == pfsa_pkg::ST_IDLE |=>
      st_reg.state != pfsa_pkg::ST_NOP1)
    else $error("keyed start without modify_permit");
  // A guarded address must refuse every keyed start.
  a_guard_block: assert property (
    guard_hit && st_reg.state == pfsa_pkg::ST_IDLE |=>
      st_reg.state != pfsa_pkg::ST_NOP1)
    else $error("keyed start inside a guarded region");

  c_read: cover property (flash_rd_en ##1 !st_reg.ctl[0]);
  c_erase: cover property (flash_erase_start ##1 cpu_stall);
  c_program: cover property (flash_prog_start ##1 cpu_stall);
  c_latch_load: cover property (
    st_reg.state == pfsa_pkg::ST_NOP2 && !st_reg.long_op);
  c_abort: cover property (dev_reset && st_reg.ctl[pfsa_pkg::CTL_PROGRAM_GO]);
endmodule // pfsa_ctrl
`default_nettype wire

// >>> core/pfsa_pkg.sv
/*
 * Shared constants and types for the program flash self-access controller.
 * Assumes a single 50 MHz instruction clock with one instruction per cycle.
 */
`default_nettype none
package pfsa_pkg;
  // Word and address widths.
  localparam int DATA_W     = 14;
  localparam int ADDR_W     = 15;
  localparam int ROW_WORDS  = 32;
  localparam int LATCH_W    = 5;
  // Blank value of a write latch.
  localparam logic [13:0] BLANK_WORD = 14'h3FFF;
  // Unlock key values, in the order they must arrive.
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // Bit positions inside flash_control_reg.
  localparam int CTL_READ_GO    = 0;
  localparam int CTL_PROGRAM_GO = 1;
  localparam int CTL_PERMIT     = 2;
  localparam int CTL_INTERRUPT  = 3;
  localparam int CTL_LATCH_ONLY = 4;
  localparam int CTL_ROW_CLEAR  = 5;
  localparam int CTL_CFG_SPACE  = 6;
  // Erase and program time.
  localparam int OP_TIME_US = 2000;
  localparam int CLK_MHZ    = 50;
  localparam int OP_CYCLES  = OP_TIME_US * CLK_MHZ;
  // Guard boundaries: words below these are shielded from self-write.
  localparam logic [14:0] GUARD_SMALL_END = 15'h0200;
  localparam logic [14:0] GUARD_HALF_END  = 15'h4000;
  // Guard setting encodings.
  localparam logic [1:0] GUARD_OFF   = 2'h3;
  localparam logic [1:0] GUARD_SMALL = 2'h2;
  localparam logic [1:0] GUARD_HALF  = 2'h1;
  // Register selects for the processor access port.
  typedef enum logic [2:0] {
    SEL_CTRL  = 3'h0,
    SEL_KEY   = 3'h1,
    SEL_DAT_L = 3'h2,
    SEL_DAT_H = 3'h3,
    SEL_ADR_L = 3'h4,
    SEL_ADR_H = 3'h5
  } pfsa_sel_t;
  // Processor write request, one write per cycle at most.
  typedef struct packed {
    logic       wr;
    pfsa_sel_t  sel;
    logic [7:0] wdata;
  } pfsa_req_t;
  // Sequencer states, Gray coded from ST_IDLE to ST_FINISH along the timed keyed path.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_RD_WAIT = 3'h1,
    ST_RD_SLOT = 3'h3,
    ST_NOP1    = 3'h2,
    ST_NOP2    = 3'h6,
    ST_TIMING  = 3'h7,
    ST_FINISH  = 3'h5
  } pfsa_state_t;
  // Progress through the unlock key.
  typedef enum logic [1:0] {
    KEY_NONE = 2'h0,
    KEY_HALF = 2'h1,
    KEY_OK   = 2'h3
  } pfsa_key_t;
endpackage
`default_nettype wire

// >>> sim/pfsa_flash_model.sv
/*
 * Behavioural flash array standing behind the sequencer's read port.
 * Assumes the sequencer samples the read word in the cycle of its strobe.
 */
`timescale 1ns/100ps
`default_nettype none
module pfsa_flash_model (
  // Clock.
  input  wire logic        clk,
  // Array read port.
  input  wire logic        rd_en,
  input  wire logic [14:0] addr,
  output var  logic [13:0] rd_data
);
  // Changes every cycle, so stale words outside a read are never mistaken.
  logic [13:0] noise_reg = 14'h0A5A;

  // The filler pattern advances on every clock.
  always_ff @(posedge clk) begin
    noise_reg <= noise_reg + 14'h1235;
  end

  always_comb begin
    if (rd_en) begin
      rd_data = (addr[13:0] ^ 14'h1B6D) + {13'h0, addr[14]};
    end else begin
      rd_data = noise_reg;
    end
  end
endmodule // pfsa_flash_model
`default_nettype wire

// >>> sim/program_flash_self_access_tb.sv
/*
 * Self-checking bench for the program flash self-access sequencer.
 * Assumes pfsa_pkg, pfsa_ctrl and pfsa_flash_model are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
module program_flash_self_access_tb;
  localparam int OPC = 16;  // Shortened erase and program time.
  logic                clk       = 1'b0;
  logic                rst       = 1'b1;
  logic                dev_reset = 1'b0;
  pfsa_pkg::pfsa_req_t req       = '0;
  pfsa_pkg::pfsa_sel_t rd_sel    = pfsa_pkg::SEL_CTRL;
  logic                lock      = 1'b1;
  logic [1:0]          guard     = pfsa_pkg::GUARD_OFF;
  logic                bulk      = 1'b0;
  logic [7:0]          rdata;
  logic                nop, stall, rd_en, er_go, pr_go, ext_ok;
  logic [14:0]         faddr;
  logic [13:0]         fdata;
  logic [31:0][13:0]   row;
  int                  err_total   = 0;
  int                  checks_done = 0;

  pfsa_ctrl #(.OP_CYCLES(OPC)) u_dut (
    .clk(clk), .rst(rst), .dev_reset(dev_reset), .cpu_req(req),
    .cpu_rd_sel(rd_sel), .cpu_rdata(rdata), .cpu_force_nop(nop),
    .cpu_stall(stall), .flash_rd_en(rd_en), .flash_addr(faddr),
    .flash_rd_data(fdata), .flash_erase_start(er_go),
    .flash_prog_start(pr_go), .flash_row_data(row),
    .readout_lock(lock), .self_program_guard(guard),
    .bulk_erase(bulk), .ext_access_ok(ext_ok));
  pfsa_flash_model u_flash (
    .clk(clk), .rd_en(rd_en), .addr(faddr), .rd_data(fdata));

  // Free-running 50 MHz instruction clock.
  always #10 clk = ~clk;

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Compares one value; four-state so an unknown never matches.
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Advances n edges and lands 2 ns after the last one.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // One register write; the idle cycle after it keeps strobes apart.
  task automatic wr(input pfsa_pkg::pfsa_sel_t sel, input logic [7:0] d);
    req = '{wr: 1'b1, sel: sel, wdata: d};
    step(1);
    req.wr = 1'b0;
    step(1);
  endtask

  // Reads a register through the one-cycle read port.
  task automatic rd(input pfsa_pkg::pfsa_sel_t sel, output logic [7:0] d);
    rd_sel = sel;
    step(1);
    d = rdata;
  endtask

  // Word the array model returns for an address.
  function automatic logic [13:0] arr_word(input logic [14:0] a);
    return (a[13:0] ^ 14'h1B6D) + {13'h0, a[14]};
  endfunction

  // Loads both address halves, high part into the high register.
  task automatic set_addr(input logic [14:0] a);
    wr(pfsa_pkg::SEL_ADR_L, a[7:0]);
    wr(pfsa_pkg::SEL_ADR_H, {1'b0, a[14:8]});
  endtask

  // Settings first, then the two keys and the start bit.
  task automatic keyed(input logic [7:0] ctl, input logic k2);
    wr(pfsa_pkg::SEL_CTRL, ctl);
    wr(pfsa_pkg::SEL_KEY, pfsa_pkg::KEY_FIRST);
    if (!k2) begin
      wr(pfsa_pkg::SEL_DAT_L, 8'h00);
    end
    wr(pfsa_pkg::SEL_KEY, pfsa_pkg::KEY_SECOND);
    wr(pfsa_pkg::SEL_CTRL, ctl | 8'h02);
  endtask

  // Indirect read with cycle stealing, then data retention.
  task automatic t_read(input logic [14:0] a);
    logic [7:0] l, h;
    set_addr(a);
    wr(pfsa_pkg::SEL_CTRL, 8'h01);
    chk("read strobe", 16'h1, 16'(rd_en));
    chk("read slot nop", 16'h1, 16'(nop));
    chk("array addr", 16'(a), 16'(faddr));
    step(1);
    chk("nop after read", 16'h0, 16'(nop));
    rd(pfsa_pkg::SEL_DAT_L, l);
    rd(pfsa_pkg::SEL_DAT_H, h);
    chk("data pair", {2'b00, arr_word(a)}, {h, l});
    rd(pfsa_pkg::SEL_CTRL, l);
    chk("read go cleared", 16'h0, 16'(l));
    step(3);
    rd(pfsa_pkg::SEL_DAT_L, l);
    chk("data kept", 16'(arr_word(a) & 14'h00FF), 16'(l));
  endtask

  // Keyed latch load: second forced slot, no stall, latch filled.
  task automatic t_load(input logic [4:0] idx, input logic [13:0] w);
    logic [7:0] c;
    set_addr({10'h2C1, idx});
    wr(pfsa_pkg::SEL_DAT_L, w[7:0]);
    wr(pfsa_pkg::SEL_DAT_H, {2'b00, w[13:8]});
    keyed(8'h14, 1'b1);
    chk("load nop", 16'h1, 16'(nop));
    chk("load stall", 16'h0, 16'(stall));
    step(1);
    chk("load nop end", 16'h0, 16'(nop));
    chk("load stall", 16'h0, 16'(stall));
    chk("latch word", 16'(w), 16'(row[idx]));
    // The start bit drops one cycle after the latch is written.
    step(1);
    rd(pfsa_pkg::SEL_CTRL, c);
    chk("program go cleared", 16'h14, 16'(c));
  endtask

  // Erase or program: pulse, stall of the timed length, blank latches.
  task automatic t_timed(input logic [7:0] ctl, input logic erase);
    int n;
    logic [7:0] c;
    keyed(ctl, 1'b1);
    step(1);
    chk("erase pulse", 16'(erase), 16'(er_go));
    chk("program pulse", 16'(!erase), 16'(pr_go));
    n = 0;
    while (stall === 1'b1 && n < 100) begin
      n++;
      step(1);
    end
    if (n >= 100) begin
      err_total++;
      close_out();
    end
    chk("stall length", 16'(OPC), 16'(n));
    chk("latch 0 blank", 16'(pfsa_pkg::BLANK_WORD), 16'(row[0]));
    chk("latch 31 blank", 16'(pfsa_pkg::BLANK_WORD), 16'(row[31]));
    // The start bit drops one cycle after the stall ends.
    step(1);
    rd(pfsa_pkg::SEL_CTRL, c);
    chk("program go cleared", 16'(ctl), 16'(c));
  endtask

  // A start that must be refused: no forced slot, start bit stays low.
  task automatic t_refused(input logic [7:0] ctl, input logic k2);
    logic [7:0] c;
    keyed(ctl, k2);
    chk("refused nop", 16'h0, 16'(nop));
    rd(pfsa_pkg::SEL_CTRL, c);
    chk("refused go", 16'(ctl), 16'(c));
  endtask

  // State straight after power-on reset, and the write-only key register.
  task automatic t_after_reset();
    logic [7:0] c;
    rd(pfsa_pkg::SEL_CTRL, c);
    chk("ctrl at reset", 16'h0, 16'(c));
    chk("latch at reset", 16'(pfsa_pkg::BLANK_WORD), 16'(row[7]));
    chk("external open", 16'h1, 16'(ext_ok));
    wr(pfsa_pkg::SEL_KEY, pfsa_pkg::KEY_FIRST);
    rd(pfsa_pkg::SEL_KEY, c);
    chk("key reads zero", 16'h0, 16'(c));
  endtask

  // A software write to the low data register replaces the low byte read before.
  task automatic t_data_write();
    logic [7:0] c;
    wr(pfsa_pkg::SEL_DAT_L, 8'hC3);
    rd(pfsa_pkg::SEL_DAT_L, c);
    chk("data written", 16'h00C3, 16'(c));
  endtask

  // Starts refused by config space, by the full guard and by the small guard.
  task automatic t_guard();
    t_refused(8'h54, 1'b1);
    guard = 2'h0;
    t_refused(8'h14, 1'b1);
    guard = pfsa_pkg::GUARD_SMALL;
    set_addr(15'h0105);
    t_refused(8'h14, 1'b1);
    // Half guard leaves the upper rows open for the loads that follow.
    guard = pfsa_pkg::GUARD_HALF;
  endtask

  // A device reset in mid-program leaves the interrupted flag behind.
  task automatic t_abort();
    logic [7:0] c;
    keyed(8'h04, 1'b1);
    step(3);
    chk("stall before abort", 16'h1, 16'(stall));
    dev_reset = 1'b1;
    step(1);
    dev_reset = 1'b0;
    chk("stall after abort", 16'h0, 16'(stall));
    rd(pfsa_pkg::SEL_CTRL, c);
    chk("interrupted flag", 16'h08, 16'(c));
  endtask

  // Readout lock is sticky until a bulk erase; self-write still works.
  task automatic t_lock();
    lock = 1'b0;
    step(2);
    chk("external blocked", 16'h0, 16'(ext_ok));
    lock = 1'b1;
    step(2);
    chk("lock sticky", 16'h0, 16'(ext_ok));
    t_load(5'h09, 14'h3001);
    bulk = 1'b1;
    step(2);
    bulk = 1'b0;
    step(2);
    chk("bulk erase unlocks", 16'h1, 16'(ext_ok));
  endtask

  // Main sequence: power-on reset for 20 cycles, then every scenario.
  initial begin
    repeat (20) @(posedge clk);
    #2;
    rst = 1'b0;
    step(2);
    t_after_reset();
    t_read(15'h7FE3);
    t_read(15'h0155);
    t_data_write();
    t_load(5'h00, 14'h2A51);
    t_load(5'h1F, 14'h15AE);
    t_refused(8'h14, 1'b0);
    t_refused(8'h10, 1'b1);
    t_guard();
    t_load(5'h03, 14'h0C0F);
    t_timed(8'h04, 1'b0);
    // A loaded latch makes the blank check after the erase meaningful.
    t_load(5'h00, 14'h1234);
    t_timed(8'h24, 1'b1);
    t_abort();
    t_lock();
    close_out();
  end
endmodule // program_flash_self_access_tb
`default_nettype wire
